// *** src/tos_defines.svh ***
// constants for the timing output select block
`ifndef TOS_DEFINES_SVH
`define TOS_DEFINES_SVH

`define TOS_AW 4
`define TOS_DW 32

`define TOS_ADDR_SEL 4'h0
`define TOS_ADDR_DRIVE 4'h4
`define TOS_ADDR_DIV 4'h8
`define TOS_ADDR_STATUS 4'hC

`define TOS_SRC_HSYNC 4'h0
`define TOS_SRC_HBLANK 4'h1
`define TOS_SRC_VSYNC 4'h2
`define TOS_SRC_VBLANK 4'h3
`define TOS_SRC_FSYNC 4'h4
`define TOS_SRC_FDIGITAL 4'h5
`define TOS_SRC_DE 4'h6
`define TOS_SRC_FID10 4'h7
`define TOS_SRC_AFS 4'h8
`define TOS_SRC_USER1 4'h9
`define TOS_SRC_USER2 4'hA
`define TOS_SRC_USER3 4'hB
`define TOS_SRC_USER4 4'hC

`define TOS_SEL_RESET 16'h3210
`define TOS_DRIVE_RESET 4'h0
`define TOS_DIV_RESET 8'h03
`define TOS_VSTD_OFF 6'h00

`define TOS_SEL_W 4
`define TOS_NPINS 4
`define TOS_DIV_W 8

`endif

// *** src/tos_pin_cell.sv ***
// one timing output pin: source pick, retimed to the pixel rate
`timescale 1ns/1ps

module tos_pin_cell import tos_pkg::*; #(
    parameter bit AUDIO_CAPABLE = 1'b1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pix_en,
    input tos_timing_t src,
    input tos_sel_t sel,
    input wire logic drive_en,
    output logic val,
    output logic oe
);
    logic val_reg;
    logic val_next;
    logic oe_reg;
    logic oe_next;

    // selection is sampled only at a pixel edge so a host write cannot glitch the pin
    always_comb begin
        val_next = val_reg;
        oe_next = oe_reg;
        if (pix_en) begin
            val_next = tos_pick(src, sel, AUDIO_CAPABLE);
            oe_next = drive_en;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            val_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            val_reg <= val_next;
            oe_reg <= oe_next;
        end
    end

    assign val = val_reg;
    assign oe = oe_reg;
endmodule

// *** src/tos_pix_div.sv ***
// pixel rate divider: enable pulse plus the two pixel clock pins
`timescale 1ns/1ps
`include "tos_defines.svh"

module tos_pix_div import tos_pkg::*; #(
    parameter int DIV_W = `TOS_DIV_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [DIV_W-1:0] ratio,
    output logic pix_en,
    output logic pclk_a,
    output logic pclk_c
);
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic en_reg;
    logic en_next;
    logic pclk_reg;
    logic pclk_next;

    // a lowered ratio mid-period wraps at once instead of running past it
    always_comb begin
        if (cnt_reg >= ratio) begin
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
        en_next = (cnt_next == '0);
        pclk_next = (cnt_next <= (ratio >> 1));
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
            en_reg <= 1'b0;
            pclk_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            en_reg <= en_next;
            pclk_reg <= pclk_next;
        end
    end

    // the enable coincides with the rising edge of both pixel clocks
    assign pix_en = en_reg;
    assign pclk_a = pclk_reg;
    assign pclk_c = pclk_reg;
endmodule

// *** src/tos_pkg.sv ***
// types and source decode for the timing output select block
`include "tos_defines.svh"

package tos_pkg;

    typedef struct packed {
        logic hsync;
        logic hblank;
        logic vsync;
        logic vblank;
        logic fsync;
        logic fdigital;
        logic de;
        logic fid10;
        logic audio_frame_sync;
        logic [3:0] user;
    } tos_timing_t;

    typedef logic [`TOS_SEL_W-1:0] tos_sel_t;

    // unused codes and afs on a part without audio give a steady low
    function automatic logic tos_pick(tos_timing_t s, tos_sel_t sel, logic afs_ok);
        logic y;
        y = 1'b0;
        case (sel)
            `TOS_SRC_HSYNC: y = s.hsync;
            `TOS_SRC_HBLANK: y = s.hblank;
            `TOS_SRC_VSYNC: y = s.vsync;
            `TOS_SRC_VBLANK: y = s.vblank;
            `TOS_SRC_FSYNC: y = s.fsync;
            `TOS_SRC_FDIGITAL: y = s.fdigital;
            `TOS_SRC_DE: y = s.de;
            `TOS_SRC_FID10: y = s.fid10;
            `TOS_SRC_AFS: y = s.audio_frame_sync & afs_ok;
            `TOS_SRC_USER1: y = s.user[0];
            `TOS_SRC_USER2: y = s.user[1];
            `TOS_SRC_USER3: y = s.user[2];
            `TOS_SRC_USER4: y = s.user[3];
            default: y = 1'b0;
        endcase
        return y;
    endfunction

endpackage

// *** src/tos_top.sv ***
// timing output select block: four selectable timing pins
// Functional notes
// - each pin shows one of hsync, hblank, vsync, vblank, fsync, fdigital, de, fid, afs, user
// - pins change only at pixel clock edges, aligned to the pixel clock outputs
// - after reset the first pin carries horizontal sync
// - after reset the second pin carries horizontal blanking
// - after reset the third pin carries vertical sync
// - per pin high or low drive set by host, low after reset
// - all pins high impedance while the video standard select is zero
`timescale 1ns/1ps
`include "tos_defines.svh"

module tos_top import tos_pkg::*; #(
    parameter bit AUDIO_CAPABLE = 1'b1,
    parameter int NPINS = `TOS_NPINS,
    parameter int DIV_W = `TOS_DIV_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input tos_timing_t src,
    input wire logic [5:0] video_standard_select,
    input wire logic [`TOS_AW-1:0] bus_addr,
    input wire logic [`TOS_DW-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [`TOS_DW-1:0] bus_rdata,
    output logic [NPINS-1:0] timing_out_val,
    output logic [NPINS-1:0] timing_out_oe,
    output logic [NPINS-1:0] timing_out_drive_hi,
    output logic pixel_clock_out_a,
    output logic pixel_clock_out_c
);
    logic [NPINS*`TOS_SEL_W-1:0] sel_reg;
    logic [NPINS*`TOS_SEL_W-1:0] sel_next;
    logic [NPINS-1:0] drive_reg;
    logic [NPINS-1:0] drive_next;
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic [`TOS_DW-1:0] rdata_reg;
    logic [`TOS_DW-1:0] rdata_next;
    logic sel_touched_reg;
    logic sel_touched_next;
    logic drv_touched_reg;
    logic drv_touched_next;
    logic [5:0] vs_meta_reg;
    logic [5:0] vs_sync_reg;
    logic vstd_on;
    logic pix_en;
    logic [NPINS-1:0] val_w;
    logic [NPINS-1:0] oe_w;
    logic [`TOS_DW-1:0] status_w;

    // video standard arrives from pins: two flops before any use
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vs_meta_reg <= `TOS_VSTD_OFF;
            vs_sync_reg <= `TOS_VSTD_OFF;
        end else begin
            vs_meta_reg <= video_standard_select;
            vs_sync_reg <= vs_meta_reg;
        end
    end

    // off at reset too, so pins stay released until a standard is seen
    assign vstd_on = (vs_sync_reg != `TOS_VSTD_OFF);

    assign status_w = {
        18'h0_0000,
        vs_sync_reg,
        oe_w,
        val_w
    };

    always_comb begin
        sel_next = sel_reg;
        drive_next = drive_reg;
        div_next = div_reg;
        sel_touched_next = sel_touched_reg;
        drv_touched_next = drv_touched_reg;
        rdata_next = '0;
        if (bus_wr) begin
            case (bus_addr)
                `TOS_ADDR_SEL: begin
                    sel_next = bus_wdata[NPINS*`TOS_SEL_W-1:0];
                    sel_touched_next = 1'b1;
                end
                `TOS_ADDR_DRIVE: begin
                    drive_next = bus_wdata[NPINS-1:0];
                    drv_touched_next = 1'b1;
                end
                `TOS_ADDR_DIV: begin
                    div_next = bus_wdata[DIV_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (bus_rd) begin
            case (bus_addr)
                `TOS_ADDR_SEL: rdata_next = `TOS_DW'(sel_reg);
                `TOS_ADDR_DRIVE: rdata_next = `TOS_DW'(drive_reg);
                `TOS_ADDR_DIV: rdata_next = `TOS_DW'(div_reg);
                `TOS_ADDR_STATUS: rdata_next = status_w;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_reg <= `TOS_SEL_RESET;
            drive_reg <= `TOS_DRIVE_RESET;
            div_reg <= `TOS_DIV_RESET;
            rdata_reg <= '0;
            sel_touched_reg <= 1'b0;
            drv_touched_reg <= 1'b0;
        end else begin
            sel_reg <= sel_next;
            drive_reg <= drive_next;
            div_reg <= div_next;
            rdata_reg <= rdata_next;
            sel_touched_reg <= sel_touched_next;
            drv_touched_reg <= drv_touched_next;
        end
    end

    tos_pix_div #(
        .DIV_W(DIV_W)
    ) u_div (
        .clk(clk),
        .arst_n(arst_n),
        .ratio(div_reg),
        .pix_en(pix_en),
        .pclk_a(pixel_clock_out_a),
        .pclk_c(pixel_clock_out_c)
    );

    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        tos_pin_cell #(
            .AUDIO_CAPABLE(AUDIO_CAPABLE)
        ) u_pin (
            .clk(clk),
            .arst_n(arst_n),
            .pix_en(pix_en),
            .src(src),
            .sel(sel_reg[i*`TOS_SEL_W +: `TOS_SEL_W]),
            .drive_en(vstd_on),
            .val(val_w[i]),
            .oe(oe_w[i])
        );
    end

    assign timing_out_val = val_w;
    assign timing_out_oe = oe_w;
    assign timing_out_drive_hi = drive_reg;
    assign bus_rdata = rdata_reg;

    // checks on the pins, the bus and the synchroniser
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // pin four follows the decoded source of its own selection
    property p_pin_source;
        pix_en |=> timing_out_val[3] ==
            tos_pick($past(src), $past(sel_reg[15:12]), AUDIO_CAPABLE);
    endproperty
    a_pin_source: assert property (p_pin_source)
        else $error("pin four does not follow its selected source");

    // between pixel enables nothing on the pins may move
    property p_pixel_aligned;
        !pix_en |=> $stable(timing_out_val) && $stable(timing_out_oe);
    endproperty
    a_pixel_aligned: assert property (p_pixel_aligned)
        else $error("timing pin changed away from a pixel edge");

    // pixel clocks rise exactly when the pins are allowed to update
    property p_clock_edge;
        pix_en |-> pixel_clock_out_a && pixel_clock_out_c;
    endproperty
    a_clock_edge: assert property (p_clock_edge)
        else $error("pixel enable not at a pixel clock high phase");

    property p_default_hsync;
        pix_en && !sel_touched_reg |=> timing_out_val[0] == $past(src.hsync);
    endproperty
    a_default_hsync: assert property (p_default_hsync)
        else $error("first pin not carrying horizontal sync by default");

    property p_default_hblank;
        pix_en && !sel_touched_reg |=> timing_out_val[1] == $past(src.hblank);
    endproperty
    a_default_hblank: assert property (p_default_hblank)
        else $error("second pin not carrying horizontal blanking by default");

    property p_default_vsync;
        pix_en && !sel_touched_reg |=> timing_out_val[2] == $past(src.vsync);
    endproperty
    a_default_vsync: assert property (p_default_vsync)
        else $error("third pin not carrying vertical sync by default");

    // drive stays low until written, then takes the written bits next cycle
    property p_drive_default;
        !drv_touched_reg |-> timing_out_drive_hi == `TOS_DRIVE_RESET;
    endproperty
    a_drive_default: assert property (p_drive_default)
        else $error("drive strength not low before any write");

    property p_drive_write;
        bus_wr && bus_addr == `TOS_ADDR_DRIVE
            |=> timing_out_drive_hi == $past(bus_wdata[NPINS-1:0]);
    endproperty
    a_drive_write: assert property (p_drive_write)
        else $error("drive strength write not applied");

    // a zero standard seen after the synchroniser releases pins at next enable
    property p_hiz_off;
        !vstd_on && pix_en |=> timing_out_oe == '0;
    endproperty
    a_hiz_off: assert property (p_hiz_off)
        else $error("timing pin driven while no standard is selected");

    property p_hiz_on;
        vstd_on && pix_en |=> timing_out_oe == '1;
    endproperty
    a_hiz_on: assert property (p_hiz_on)
        else $error("timing pin not driven with a standard selected");

    // a new selection reaches the pin only with the next pixel enable
    property p_sel_at_edge;
        bus_wr && bus_addr == `TOS_ADDR_SEL ##1 !pix_en
            |=> $stable(timing_out_val);
    endproperty
    a_sel_at_edge: assert property (p_sel_at_edge)
        else $error("selection change took effect between pixel edges");

    property p_read_unmapped;
        bus_rd && bus_addr > `TOS_ADDR_STATUS |=> bus_rdata == '0;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped)
        else $error("unmapped read did not return zero");

    // read data stand for one cycle only, zero otherwise
    property p_rdata_idle;
        !bus_rd |=> bus_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without a read");

    property p_read_drive;
        bus_rd && bus_addr == `TOS_ADDR_DRIVE
            |=> bus_rdata == `TOS_DW'($past(drive_reg));
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("drive strength read back wrong");

    // drive strength moves only on a write to its own register
    property p_drive_hold;
        !(bus_wr && bus_addr == `TOS_ADDR_DRIVE) |=> $stable(timing_out_drive_hi);
    endproperty
    a_drive_hold: assert property (p_drive_hold)
        else $error("drive strength changed without a write");

    property p_sel_write;
        bus_wr && bus_addr == `TOS_ADDR_SEL
            |=> sel_reg == $past(bus_wdata[NPINS*`TOS_SEL_W-1:0]);
    endproperty
    a_sel_write: assert property (p_sel_write)
        else $error("source selection write not applied");

    // the two pixel clock pins never drift apart
    property p_clock_pair;
        pixel_clock_out_a == pixel_clock_out_c;
    endproperty
    a_clock_pair: assert property (p_clock_pair)
        else $error("pixel clock outputs differ");

    // enables are released or driven as a group, never split
    property p_oe_group;
        timing_out_oe == '0 || timing_out_oe == '1;
    endproperty
    a_oe_group: assert property (p_oe_group)
        else $error("timing pin enables split between pins");

    // second synchroniser stage copies the first one cycle late
    property p_vstd_sync;
        vs_sync_reg == $past(vs_meta_reg);
    endproperty
    a_vstd_sync: assert property (p_vstd_sync)
        else $error("video standard synchroniser skipped a stage");

    // each pin takes its own selected source at every pixel enable
    for (genvar k = 0; k < NPINS; k++) begin : g_chk
        property p_pin_follow;
            pix_en |=> timing_out_val[k] == tos_pick($past(src),
                $past(sel_reg[k*`TOS_SEL_W +: `TOS_SEL_W]), AUDIO_CAPABLE);
        endproperty
        a_pin_follow: assert property (p_pin_follow)
            else $error("timing pin does not follow its selected source");
    end

    c_sel_write: cover property (
        bus_wr && bus_addr == `TOS_ADDR_SEL ##[1:300] pix_en);
    c_hiz: cover property (vstd_on ##1 !vstd_on ##[1:300] timing_out_oe == '0);
    c_drive: cover property (bus_wr && bus_addr == `TOS_ADDR_DRIVE
        ##1 timing_out_drive_hi != '0);
    c_status: cover property (bus_rd && bus_addr == `TOS_ADDR_STATUS);

endmodule

// *** test/testbench.sv ***
// self-checking bench for the timing output select block
`timescale 1ns/1ps

module testbench;
    import tos_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    tos_timing_t src = '0;
    logic [5:0] vstd = 6'h00;
    logic [3:0] bus_addr = 4'h0;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic [3:0] tval;
    logic [3:0] toe;
    logic [3:0] tdrv;
    logic pclk_a;
    logic pclk_c;
    logic [3:0] na_val;
    logic [3:0] captured;
    int off_step_cnt;
    int error_cnt = 0;
    int checks = 0;
    logic [31:0] rd_val;

    always #2 clk = ~clk;

    tos_top uut (.clk(clk), .arst_n(arst_n), .src(src), .video_standard_select(vstd),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .timing_out_val(tval), .timing_out_oe(toe),
        .timing_out_drive_hi(tdrv), .pixel_clock_out_a(pclk_a), .pixel_clock_out_c(pclk_c));

    // variant without audio: the audio frame sync code must give a steady low
    tos_top #(.AUDIO_CAPABLE(1'b0)) uut_noaudio (.clk(clk), .arst_n(arst_n), .src(src),
        .video_standard_select(vstd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(), .timing_out_val(na_val),
        .timing_out_oe(), .timing_out_drive_hi(), .pixel_clock_out_a(),
        .pixel_clock_out_c());

    tos_sink_model sink (.clk(clk), .arst_n(arst_n), .pclk(pclk_a), .pin_val(tval),
        .pin_oe(toe), .captured(captured), .off_step_cnt(off_step_cnt));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    // read data are valid only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    // longest path: select write, one pixel period of 4 clocks, pin register
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    task automatic tally_and_finish();
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic t_reset_values();
        rd(4'h0, rd_val);
        chk(rd_val, 32'h0000_3210);
        rd(4'h4, rd_val);
        chk(rd_val, 32'h0000_0000);
        chk(tdrv, 4'h0);
        rd(4'h2, rd_val);
        chk(rd_val, 32'h0000_0000);
        wr(4'hC, 32'hFFFF_FFFF);
        rd(4'hC, rd_val);
        chk(rd_val, 32'h0000_0000);
    endtask

    task automatic t_high_z_off();
        int n;
        settle();
        chk(toe, 4'h0);
        @(posedge clk);
        vstd <= 6'h21;
        n = 0;
        while (toe !== 4'hF && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, toe, 4'hF);
            tally_and_finish();
        end
        rd(4'hC, rd_val);
        chk(rd_val, 32'h0000_21F0);
    endtask

    task automatic t_defaults();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            src <= tos_timing_t'(13'h1000 >> i);
            settle();
            chk(tval, 4'h1 << i);
        end
        chk(captured, 4'h8);
    endtask

    // every source code on pin 0, high and low, so a wrong pick shows
    task automatic t_all_sources();
        logic [12:0] one;
        for (int c = 0; c < 13; c++) begin
            one = (c < 9) ? (13'h1000 >> c) : (13'h0001 << (c - 9));
            wr(4'h0, {28'h000_3210, 4'(c)});
            @(posedge clk);
            src <= tos_timing_t'(one);
            settle();
            chk(tval[0], 1'b1);
            chk(na_val[0], (c == 8) ? 1'b0 : 1'b1);
            @(posedge clk);
            src <= tos_timing_t'(~one);
            settle();
            chk(tval[0], 1'b0);
        end
        wr(4'h0, 32'h0000_321D);
        @(posedge clk);
        src <= tos_timing_t'(13'h1FFF);
        settle();
        chk(tval, 4'hE);
    endtask

    task automatic t_drive();
        wr(4'h4, 32'h0000_0005);
        @(posedge clk);
        #1;
        chk(tdrv, 4'h5);
        rd(4'h4, rd_val);
        chk(rd_val, 32'h0000_0005);
    endtask

    // both pixel clocks alike, high for two of every four clocks
    task automatic t_pixel_clocks();
        int hi_both;
        int hi_either;
        hi_both = 0;
        hi_either = 0;
        repeat (8) begin
            @(posedge clk);
            hi_both += pclk_a & pclk_c;
            hi_either += pclk_a | pclk_c;
        end
        chk(hi_both, 4);
        chk(hi_either, 4);
    endtask

    task automatic t_back_to_off();
        @(posedge clk);
        vstd <= 6'h00;
        repeat (12) @(posedge clk);
        chk(toe, 4'h0);
        chk(off_step_cnt, 0);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        t_reset_values();
        t_high_z_off();
        t_defaults();
        t_all_sources();
        t_drive();
        t_pixel_clocks();
        t_back_to_off();
        tally_and_finish();
    end
endmodule

// *** test/tos_sink_model.sv ***
// downstream video logic model: captures the timing pins on the pixel clock
`timescale 1ns/1ps

module tos_sink_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pclk,
    input wire logic [3:0] pin_val,
    input wire logic [3:0] pin_oe,
    output logic [3:0] captured,
    output int off_step_cnt
);
    logic [7:0] last_pins;
    logic pclk_d;
    logic rose_d;

    // a released pin is read low, as if the board held it down
    always @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            captured <= 4'h0;
        end else begin
            captured <= pin_val & pin_oe;
        end
    end

    // pins may only move on the clock that follows a pixel clock rise
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_pins <= 8'h00;
            pclk_d <= 1'b0;
            rose_d <= 1'b0;
            off_step_cnt <= 0;
        end else begin
            if ({pin_oe, pin_val} !== last_pins && !rose_d) begin
                off_step_cnt <= off_step_cnt + 1;
            end
            last_pins <= {pin_oe, pin_val};
            rose_d <= pclk & ~pclk_d;
            pclk_d <= pclk;
        end
    end
endmodule
